// File: common/regulator_cfg_defines.vh
`ifndef REGULATOR_CFG_DEFINES_VH
`define REGULATOR_CFG_DEFINES_VH

// ==========================================================
// register offsets
`define OFS_CH4_VOLTAGE_CODE   8'h04
`define OFS_VOLTAGE_SCALING    8'h05
`define OFS_MODE_DISCHARGE     8'h06

// ==========================================================
// field positions
`define CODE_MSB               4
`define CODE_LSB               0
`define CH4_SCALE_EN_BIT       6
`define CH4_INTERVAL_MSB       5
`define CH4_INTERVAL_LSB       4
`define CH1_SCALE_EN_BIT       2
`define CH1_INTERVAL_MSB       1
`define CH1_INTERVAL_LSB       0
`define DISCHARGE_MSB          7
`define DISCHARGE_LSB          4
`define POWER_SAVE_MSB         3
`define POWER_SAVE_LSB         0

// ==========================================================
// reset values
`define SCALING_RESET          8'h00
`define POWER_SAVE_RESET       4'h0
`define ALL_AUTO_MODE          4'hf

// ==========================================================
// voltage decode in millivolts
`define CH4_ADJUST_CODE        5'h00
`define CH4_ADJUST_MV          13'h0320
`define CH4_BASE_MV            13'h0960
`define CH4_STEP_MV            13'h0064

// ==========================================================
// scaling step intervals
`define CLK_FREQ_KHZ           20000
`define STEP_T0_NS             62500
`define STEP_T1_NS             31200
`define STEP_T2_NS             15600
`define STEP_T3_NS             7800

// ==========================================================
// serial link
`define I2C_DEV_ADDR           7'h2a
`define BYTE_BITS              4'h8

`endif

// File: design/regulator_config_regs_4_to_6.v
// Summary of operation
// - bits 4:0 of register 0x04 are channel 4 voltage code; 7:5 reserved
// - channel 4 voltage code resets to the fuse value, not a constant
// - code 0 is adjustable 0.8 V feedback; codes 1..31 run 2.5 V to 5.5 V
// - channel 4 scaling enabled only by bit 6 of 0x05; resets zero
// - channel 4 step interval bits 5:4: 62.5, 31.2, 15.6, 7.8 us
// - channel 1 scaling enabled only by bit 2 of 0x05; resets zero
// - channel 1 step interval bits 1:0, same encoding, resets to 62.5 us
// - discharge switch enables in 0x06 bits 7..4 for channels 4..1, one enables
// - all four discharge bits reset from one shared fuse choice
// - mode bits 3..0 for channels 4..1: zero forced PWM (reset), one auto
// - mode pin low, when not used as sync clock, forces every channel to auto mode, ignoring mode bits
// - mode bits honoured when mode pin high or pin used as sync clock
`timescale 1ns/1ps
`include "regulator_cfg_defines.vh"

module regulator_config_regs_4_to_6 #(
  parameter [6:0] DEV_ADDR = `I2C_DEV_ADDR  // arbitrary bus address
) (
  input  wire        clk_i,
  input  wire        sys_rst_i,
  input  wire        scl_i,
  input  wire        sda_i,
  output wire        sda_o,
  output wire        sda_oe_o,
  input  wire        mode_pin_i,
  input  wire        mode_pin_is_sync_i,
  input  wire [4:0]  fuse_ch4_code_i,
  input  wire        fuse_discharge_i,
  output reg  [4:0]  ch4_voltage_code_o,
  output reg         ch4_adjustable_o,
  output reg  [12:0] ch4_target_mv_o,
  output reg         ch4_scaling_enable_o,
  output reg  [1:0]  ch4_scaling_interval_o,
  output reg  [10:0] ch4_step_cycles_o,
  output reg         ch1_scaling_enable_o,
  output reg  [1:0]  ch1_scaling_interval_o,
  output reg  [10:0] ch1_step_cycles_o,
  output reg  [3:0]  discharge_enable_o,
  output reg  [3:0]  power_save_o
);

  // ==========================================================
  // step interval counts, rounded up to whole cycles
  localparam integer STEP_N0 = (`STEP_T0_NS * `CLK_FREQ_KHZ + 999999) / 1000000;
  localparam integer STEP_N1 = (`STEP_T1_NS * `CLK_FREQ_KHZ + 999999) / 1000000;
  localparam integer STEP_N2 = (`STEP_T2_NS * `CLK_FREQ_KHZ + 999999) / 1000000;
  localparam integer STEP_N3 = (`STEP_T3_NS * `CLK_FREQ_KHZ + 999999) / 1000000;
  // counts fit in 11 bits at 20 MHz; cut the integers on purpose
  localparam [10:0] STEP_C0 = STEP_N0[10:0];
  localparam [10:0] STEP_C1 = STEP_N1[10:0];
  localparam [10:0] STEP_C2 = STEP_N2[10:0];
  localparam [10:0] STEP_C3 = STEP_N3[10:0];

  localparam [2:0] S_IDLE  = 3'h0;
  localparam [2:0] S_RX    = 3'h1;
  localparam [2:0] S_ACK   = 3'h2;
  localparam [2:0] S_TX    = 3'h3;
  localparam [2:0] S_TXACK = 3'h4;

  localparam [1:0] PH_ADDR = 2'h0;
  localparam [1:0] PH_PTR  = 2'h1;
  localparam [1:0] PH_DATA = 2'h2;

  // ==========================================================
  // pin synchronisers
  wire [2:0] pins_s;
  wire       scl_s;
  wire       sda_s;
  wire       mode_s;

  two_flop_sync #(
    .WIDTH (3)
  ) u_sync (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .async_i   ({mode_pin_i, sda_i, scl_i}),
    .sync_o    (pins_s)
  );

  assign scl_s  = pins_s[0];
  assign sda_s  = pins_s[1];
  assign mode_s = pins_s[2];

  reg       scl_d_r;
  reg       sda_d_r;
  wire      scl_rise;
  wire      scl_fall;
  wire      start_cond;
  wire      stop_cond;

  assign scl_rise   = scl_s & ~scl_d_r;
  assign scl_fall   = ~scl_s & scl_d_r;
  assign start_cond = scl_s & scl_d_r & sda_d_r & ~sda_s;
  assign stop_cond  = scl_s & scl_d_r & ~sda_d_r & sda_s;

  // ==========================================================
  // registers
  reg  [7:0] voltage_r;
  reg  [7:0] scaling_r;
  reg  [7:0] mode_r;
  reg  [7:0] rdata;
  reg        wr_en;
  reg  [7:0] wr_ptr;
  reg  [7:0] wr_data;

  // full byte is readable, reserved bits included
  always @* begin
    case (wr_ptr)
      `OFS_CH4_VOLTAGE_CODE: rdata = voltage_r;
      `OFS_VOLTAGE_SCALING:  rdata = scaling_r;
      `OFS_MODE_DISCHARGE:   rdata = mode_r;
      default:               rdata = 8'h00;
    endcase
  end

  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      voltage_r <= {3'h0, fuse_ch4_code_i};
      scaling_r <= `SCALING_RESET;
      mode_r    <= {{4{fuse_discharge_i}}, `POWER_SAVE_RESET};
    end else if (wr_en) begin
      case (wr_ptr)
        `OFS_CH4_VOLTAGE_CODE: voltage_r <= wr_data;
        `OFS_VOLTAGE_SCALING:  scaling_r <= wr_data;
        `OFS_MODE_DISCHARGE:   mode_r    <= wr_data;
        default:               voltage_r <= voltage_r;
      endcase
    end
  end

  // ==========================================================
  // serial slave
  reg  [2:0] state_r;
  reg  [1:0] phase_r;
  reg  [3:0] bit_cnt_r;
  reg  [7:0] shift_r;
  reg  [7:0] ptr_r;
  reg        rw_r;
  reg        oe_r;
  reg        sda_out_r;

  // write strobe fires on the falling scl after a data byte
  always @* begin
    wr_en   = 1'b0;
    wr_ptr  = ptr_r;
    wr_data = shift_r;
    if (state_r == S_RX && scl_fall && bit_cnt_r == `BYTE_BITS && phase_r == PH_DATA) begin
      wr_en = 1'b1;
    end
  end

  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      scl_d_r   <= 1'b1;
      sda_d_r   <= 1'b1;
      state_r   <= S_IDLE;
      phase_r   <= PH_ADDR;
      bit_cnt_r <= 4'h0;
      shift_r   <= 8'h00;
      ptr_r     <= 8'h00;
      rw_r      <= 1'b0;
      oe_r      <= 1'b0;
      sda_out_r <= 1'b0;
    end else begin
      scl_d_r <= scl_s;
      sda_d_r <= sda_s;
      if (start_cond) begin
        state_r   <= S_RX;
        phase_r   <= PH_ADDR;
        bit_cnt_r <= 4'h0;
        oe_r      <= 1'b0;
      end else if (stop_cond) begin
        state_r <= S_IDLE;
        oe_r    <= 1'b0;
      end else begin
        case (state_r)
          S_RX: begin
            if (scl_rise) begin
              shift_r   <= {shift_r[6:0], sda_s};
              bit_cnt_r <= bit_cnt_r + 4'h1;
            end else if (scl_fall && bit_cnt_r == `BYTE_BITS) begin
              bit_cnt_r <= 4'h0;
              if (phase_r == PH_ADDR) begin
                if (shift_r[7:1] == DEV_ADDR) begin
                  rw_r    <= shift_r[0];
                  phase_r <= PH_PTR;
                  oe_r    <= 1'b1;
                  state_r <= S_ACK;
                end else begin
                  state_r <= S_IDLE;
                end
              end else if (phase_r == PH_PTR) begin
                ptr_r   <= shift_r;
                phase_r <= PH_DATA;
                oe_r    <= 1'b1;
                state_r <= S_ACK;
              end else begin
                ptr_r   <= ptr_r + 8'h01;
                oe_r    <= 1'b1;
                state_r <= S_ACK;
              end
            end
          end
          S_ACK: begin
            if (scl_fall) begin
              bit_cnt_r <= 4'h0;
              if (rw_r) begin
                shift_r <= rdata;
                ptr_r   <= ptr_r + 8'h01;
                oe_r    <= ~rdata[7];
                state_r <= S_TX;
              end else begin
                oe_r    <= 1'b0;
                state_r <= S_RX;
              end
            end
          end
          S_TX: begin
            if (scl_rise) begin
              bit_cnt_r <= bit_cnt_r + 4'h1;
            end else if (scl_fall) begin
              if (bit_cnt_r == `BYTE_BITS) begin
                oe_r    <= 1'b0;
                state_r <= S_TXACK;
              end else begin
                shift_r <= {shift_r[6:0], 1'b0};
                oe_r    <= ~shift_r[6];
              end
            end
          end
          S_TXACK: begin
            // a nack ends the read; master then sends stop
            if (scl_rise && sda_s) begin
              state_r <= S_IDLE;
            end else if (scl_fall) begin
              bit_cnt_r <= 4'h0;
              shift_r   <= rdata;
              ptr_r     <= ptr_r + 8'h01;
              oe_r      <= ~rdata[7];
              state_r   <= S_TX;
            end
          end
          S_IDLE: begin
            oe_r <= 1'b0;
          end
          default: begin
            state_r <= S_IDLE;
            oe_r    <= 1'b0;
          end
        endcase
      end
    end
  end

  assign sda_o    = sda_out_r;
  assign sda_oe_o = oe_r;

  // ==========================================================
  // decoded outputs, registered
  function [10:0] step_cycles;
    input [1:0] sel;
    begin
      case (sel)
        2'h0:    step_cycles = STEP_C0;
        2'h1:    step_cycles = STEP_C1;
        2'h2:    step_cycles = STEP_C2;
        default: step_cycles = STEP_C3;
      endcase
    end
  endfunction

  wire [4:0]  code4;
  wire [12:0] fixed_mv;
  assign code4    = voltage_r[`CODE_MSB:`CODE_LSB];
  assign fixed_mv = `CH4_BASE_MV + `CH4_STEP_MV * {8'h00, code4};

  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      ch4_voltage_code_o     <= 5'h00;
      ch4_adjustable_o       <= 1'b0;
      ch4_target_mv_o        <= 13'h0000;
      ch4_scaling_enable_o   <= 1'b0;
      ch4_scaling_interval_o <= 2'h0;
      ch4_step_cycles_o      <= STEP_C0;
      ch1_scaling_enable_o   <= 1'b0;
      ch1_scaling_interval_o <= 2'h0;
      ch1_step_cycles_o      <= STEP_C0;
      discharge_enable_o     <= 4'h0;
      power_save_o           <= `ALL_AUTO_MODE;
    end else begin
      ch4_voltage_code_o <= code4;
      ch4_adjustable_o   <= (code4 == `CH4_ADJUST_CODE);
      ch4_target_mv_o    <= (code4 == `CH4_ADJUST_CODE) ? `CH4_ADJUST_MV : fixed_mv;
      ch4_scaling_enable_o   <= scaling_r[`CH4_SCALE_EN_BIT];
      ch4_scaling_interval_o <= scaling_r[`CH4_INTERVAL_MSB:`CH4_INTERVAL_LSB];
      ch4_step_cycles_o      <= step_cycles(scaling_r[`CH4_INTERVAL_MSB:`CH4_INTERVAL_LSB]);
      ch1_scaling_enable_o   <= scaling_r[`CH1_SCALE_EN_BIT];
      ch1_scaling_interval_o <= scaling_r[`CH1_INTERVAL_MSB:`CH1_INTERVAL_LSB];
      ch1_step_cycles_o      <= step_cycles(scaling_r[`CH1_INTERVAL_MSB:`CH1_INTERVAL_LSB]);
      discharge_enable_o     <= mode_r[`DISCHARGE_MSB:`DISCHARGE_LSB];
      // sync use overrides the level, since the pin toggles then
      if (mode_s || mode_pin_is_sync_i) begin
        power_save_o <= mode_r[`POWER_SAVE_MSB:`POWER_SAVE_LSB];
      end else begin
        power_save_o <= `ALL_AUTO_MODE;
      end
    end
  end

endmodule // regulator_config_regs_4_to_6

// File: design/two_flop_sync.v
`timescale 1ns/1ps

module two_flop_sync #(
  parameter WIDTH = 3
) (
  input  wire             clk_i,
  input  wire             sys_rst_i,
  input  wire [WIDTH-1:0] async_i,
  output wire [WIDTH-1:0] sync_o
);

  reg [WIDTH-1:0] meta_r;
  reg [WIDTH-1:0] sync_r;

  // ==========================================================
  // per-bit synchroniser; meta_r feeds sync_r only
  genvar g;
  generate
    for (g = 0; g < WIDTH; g = g + 1) begin : g_bit
      always @(posedge clk_i) begin
        if (sys_rst_i) begin
          meta_r[g] <= 1'b1;
          sync_r[g] <= 1'b1;
        end else begin
          meta_r[g] <= async_i[g];
          sync_r[g] <= meta_r[g];
        end
      end
    end
  endgenerate

  assign sync_o = sync_r;

endmodule // two_flop_sync

// File: dv/i2c_host_model.sv
`timescale 1ns/1ps
module i2c_host_model #(
  parameter int HALF = 10
) (
  input  wire logic clk_i,
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_oe_o
);
  // ==========================================================
  // bit level, slow phases of 5 clk keep just above the 4 clk minimum
  initial begin
    scl_o = 1'b1;
    sda_oe_o = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic bit_io(input logic b, output logic r);
    sda_oe_o = !b;
    tick(HALF / 2);
    scl_o = 1'b1;
    tick(HALF / 2);
    r = sda_i;
    tick(HALF / 2);
    scl_o = 1'b0;
    tick(HALF / 2);
  endtask
  task automatic start();
    sda_oe_o = 1'b0;
    tick(HALF / 2);
    scl_o = 1'b1;
    tick(HALF / 2);
    sda_oe_o = 1'b1;
    tick(HALF / 2);
    scl_o = 1'b0;
    tick(HALF / 2);
  endtask
  task automatic stop();
    sda_oe_o = 1'b1;
    tick(HALF / 2);
    scl_o = 1'b1;
    tick(HALF / 2);
    sda_oe_o = 1'b0;
    tick(HALF);
  endtask
  // ==========================================================
  // byte level, msb first
  task automatic xfer(input logic [7:0] d, input logic nack, output logic [7:0] q,
                      output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
      q[i] = r;
    end
    bit_io(nack, r);
    ack = !r;
  endtask
  task automatic write_reg(input logic [6:0] a, input logic [7:0] p, input logic [7:0] d,
                           output logic ok);
    logic [7:0] q;
    logic a0, a1, a2;
    start();
    xfer({a, 1'b0}, 1'b1, q, a0);
    xfer(p, 1'b1, q, a1);
    xfer(d, 1'b1, q, a2);
    stop();
    ok = a0 & a1 & a2;
  endtask
  task automatic read_reg(input logic [6:0] a, input logic [7:0] p, output logic [7:0] d,
                          output logic ok);
    logic [7:0] q;
    logic a0, a1, a2;
    start();
    xfer({a, 1'b0}, 1'b1, q, a0);
    xfer(p, 1'b1, q, a1);
    start();
    xfer({a, 1'b1}, 1'b1, q, a2);
    xfer(8'hff, 1'b1, d, a0);
    stop();
    ok = a1 & a2;
  endtask
endmodule // i2c_host_model

// File: dv/regulator_cfg_monitor.sv
`timescale 1ns/1ps
module regulator_cfg_monitor (
  input wire logic        clk_i,
  input wire logic        sys_rst_i,
  input wire logic        mode_pin_i,
  input wire logic        mode_pin_is_sync_i,
  input wire logic [4:0]  fuse_ch4_code_i,
  input wire logic        fuse_discharge_i,
  input wire logic        sda_o,
  input wire logic        sda_oe_o,
  input wire logic [4:0]  ch4_voltage_code_o,
  input wire logic        ch4_adjustable_o,
  input wire logic [12:0] ch4_target_mv_o,
  input wire logic        ch4_scaling_enable_o,
  input wire logic [1:0]  ch4_scaling_interval_o,
  input wire logic [10:0] ch4_step_cycles_o,
  input wire logic [1:0]  ch1_scaling_interval_o,
  input wire logic [10:0] ch1_step_cycles_o,
  input wire logic [3:0]  discharge_enable_o,
  input wire logic [3:0]  power_save_o
);
  // ==========================================================
  // decode helpers
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  function automatic logic [10:0] stp(input logic [1:0] k);
    return (k == 2'h0) ? 11'd1250 : (k == 2'h1) ? 11'd624 : (k == 2'h2) ? 11'd312 : 11'd156;
  endfunction
  sequence pin_low_held;
    (!mode_pin_i && !mode_pin_is_sync_i)[*4];
  endsequence
  sequence reset_released;
    sys_rst_i ##1 !sys_rst_i;
  endsequence
  // ==========================================================
  // assertions
  a_code_adjust: assert property ($stable(ch4_voltage_code_o) && !$past(sys_rst_i)
    |-> ch4_adjustable_o == (ch4_voltage_code_o == 5'h00)) else $error("adjustable flag wrong");
  a_target_mv: assert property ($stable(ch4_voltage_code_o) && !$past(sys_rst_i) |->
    ch4_target_mv_o == ((ch4_voltage_code_o == 5'h00) ? 13'd800 : 13'd2400 + 13'd100 * ch4_voltage_code_o))
    else $error("target voltage wrong");
  a_step_ch4: assert property ($stable(ch4_scaling_interval_o) |->
    ch4_step_cycles_o == stp(ch4_scaling_interval_o)) else $error("ch4 step wrong");
  a_step_ch1: assert property ($stable(ch1_scaling_interval_o) |->
    ch1_step_cycles_o == stp(ch1_scaling_interval_o)) else $error("ch1 step wrong");
  a_mode_low_auto: assert property (pin_low_held |-> power_save_o == 4'hf)
    else $error("mode pin low not forcing auto");
  a_reset_outputs: assert property (disable iff (1'b0) sys_rst_i ##1 sys_rst_i |->
    !ch4_scaling_enable_o && power_save_o == 4'hf && !sda_oe_o) else $error("reset outputs wrong");
  a_fuse_load: assert property (disable iff (1'b0) reset_released |=>
    ch4_voltage_code_o == fuse_ch4_code_i && discharge_enable_o == {4{fuse_discharge_i}})
    else $error("fuse values not loaded");
  a_open_drain: assert property (sda_oe_o |-> !sda_o) else $error("sda driven high");
endmodule // regulator_cfg_monitor
bind regulator_config_regs_4_to_6 regulator_cfg_monitor i_mon (.clk_i, .sys_rst_i, .mode_pin_i,
  .mode_pin_is_sync_i, .fuse_ch4_code_i, .fuse_discharge_i, .sda_o, .sda_oe_o, .ch4_voltage_code_o,
  .ch4_adjustable_o, .ch4_target_mv_o, .ch4_scaling_enable_o, .ch4_scaling_interval_o,
  .ch4_step_cycles_o, .ch1_scaling_interval_o, .ch1_step_cycles_o, .discharge_enable_o,
  .power_save_o);

// File: dv/regulator_config_regs_4_to_6_tb.sv
`timescale 1ns/1ps
`include "regulator_cfg_defines.vh"
module regulator_config_regs_4_to_6_tb;
  logic clk_i, sys_rst_i, mode_pin_i, mode_pin_is_sync_i, fuse_discharge_i;
  logic [4:0] fuse_ch4_code_i;
  wire scl, host_oe, sda_o, sda_oe_o, adj, en4, en1;
  wire [4:0] code;
  wire [12:0] mv;
  wire [1:0] iv4, iv1;
  wire [10:0] st4, st1;
  wire [3:0] dis, ps;
  // pull-up on the bus: released means high
  wire sda_line = !((sda_oe_o && !sda_o) || host_oe);
  int err_count = 0, checked = 0;
  int stp[4] = '{1250, 624, 312, 156};
  logic [4:0] c;
  logic ok;
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = !clk_i;
  end
  regulator_config_regs_4_to_6 i_dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .scl_i(scl),
    .sda_i(sda_line), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .mode_pin_i(mode_pin_i),
    .mode_pin_is_sync_i(mode_pin_is_sync_i), .fuse_ch4_code_i(fuse_ch4_code_i),
    .fuse_discharge_i(fuse_discharge_i), .ch4_voltage_code_o(code), .ch4_adjustable_o(adj),
    .ch4_target_mv_o(mv), .ch4_scaling_enable_o(en4), .ch4_scaling_interval_o(iv4),
    .ch4_step_cycles_o(st4), .ch1_scaling_enable_o(en1), .ch1_scaling_interval_o(iv1),
    .ch1_step_cycles_o(st1), .discharge_enable_o(dis), .power_save_o(ps));
  i2c_host_model i_host (.clk_i(clk_i), .sda_i(sda_line), .scl_o(scl), .sda_oe_o(host_oe));
  // ==========================================================
  // shared tasks
  task automatic test_done();
    $display("checked %0d errors %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] p, input logic [7:0] d);
    i_host.write_reg(`I2C_DEV_ADDR, p, d, ok);
    chk(ok, 1, "write ack");
  endtask
  task automatic rd(input logic [7:0] p, input logic [7:0] exp);
    logic [7:0] q;
    i_host.read_reg(`I2C_DEV_ADDR, p, q, ok);
    chk({ok, q}, {1'b1, exp}, "read back");
  endtask
  task automatic do_reset(input logic [4:0] fc, input logic fd);
    sys_rst_i = 1'b1;
    fuse_ch4_code_i = fc;
    fuse_discharge_i = fd;
    i_host.tick(8);
    sys_rst_i = 1'b0;
    i_host.tick(4);
  endtask
  initial begin
    repeat (90000) @(posedge clk_i);
    err_count++;
    test_done();
  end
  // ==========================================================
  // main sequence
  initial begin
    sys_rst_i = 1'b1;
    mode_pin_i = 1'b1;
    mode_pin_is_sync_i = 1'b0;
    fuse_ch4_code_i = 5'h13;
    fuse_discharge_i = 1'b1;
    do_reset(5'h13, 1'b1);
    chk({code, dis, ps}, {5'h13, 4'hf, 4'h0}, "fuse reset");
    rd(8'h04, 8'h13);
    rd(8'h05, 8'h00);
    rd(8'h06, 8'hf0);
    for (int i = 0; i < 3; i++) begin
      c = (i == 0) ? 5'h00 : (i == 1) ? 5'h01 : 5'h1f;
      wr(8'h04, {3'h5, c});
      chk({adj, mv}, {c == 5'h00, (c == 5'h00) ? 13'd800 : 13'd2400 + 13'd100 * c},
          "decode");
      rd(8'h04, {3'h5, c});
    end
    for (int k = 0; k < 4; k++) begin
      wr(8'h05, 8'hcc | (k << 4) | (3 - k));
      chk({en4, iv4, st4}, {1'b1, 2'(k), 11'(stp[k])}, "ch4 scaling");
      chk({en1, iv1, st1}, {1'b1, 2'(3 - k), 11'(stp[3 - k])},
          "ch1 scaling");
      rd(8'h05, 8'hcc | (k << 4) | (3 - k));
    end
    wr(8'h05, 8'h88);
    chk({en4, en1}, 2'b00, "scaling off");
    wr(8'h06, 8'ha5);
    chk({dis, ps}, 8'ha5, "mode pin high");
    mode_pin_i = 1'b0;
    i_host.tick(4);
    chk(ps, 4'hf, "mode pin low");
    mode_pin_is_sync_i = 1'b1;
    i_host.tick(4);
    chk(ps, 4'h5, "pin as sync");
    mode_pin_i = 1'b1;
    mode_pin_is_sync_i = 1'b0;
    i_host.write_reg(7'h2b, 8'h04, 8'h00, ok);
    chk(ok, 0, "foreign address");
    rd(8'h04, 8'hbf);
    wr(8'h07, 8'h55);
    rd(8'h07, 8'h00);
    do_reset(5'h00, 1'b0);
    chk({code, adj, mv, dis, en4}, {5'h00, 1'b1, 13'd800, 4'h0, 1'b0},
        "second reset");
    rd(8'h06, 8'h00);
    test_done();
  end
endmodule // regulator_config_regs_4_to_6_tb
